// ---- core/tcmdc_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcmdc_monitor
  import tcmdc_pkg::*;
#(
  parameter int CNT_W = TCMDC_CNT_W
) (
  input wire logic CLK_SYS, // 200 MHz clock
  input wire logic RST_B, // async reset, low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb write
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire logic FRAME_START, // frame start pulse
  input wire logic [7:0] TC_OVERHEAD, // tandem byte, valid on frame start
  input wire logic MFA_WORD_STROBE, // alignment word checked
  input wire logic MFA_WORD_ERROR, // checked word had errors
  input wire logic SERVER_SIGNAL_FAIL_IN, // upstream fail
  input wire logic TRACE_MISMATCH_RAW, // mismatch before gating
  input wire logic DEGRADE_DEFECT, // degrade defect
  input wire logic REMOTE_DEFECT, // remote defect
  input wire logic OUTGOING_DEFECT, // outgoing defect
  input wire logic EQUIPMENT_DEFECT, // equipment defect
  input wire logic NEAR_ERRORED_BLOCK_FLAG, // near errored block, on frame start
  input wire logic FAR_ERRORED_BLOCK_FLAG, // far errored block, on frame start
  input wire logic OUTGOING_FAR_ERRORED_BLOCK_FLAG, // outgoing errored block
  input wire logic ONE_SECOND, // one-second tick pulse
  output logic TRAIL_SIGNAL_FAIL_OUT, // trail signal fail
  output logic TRAIL_SIGNAL_DEGRADE_OUT, // trail signal degrade
  output tcmdc_cause_s FAULT_CAUSES, // gated fault causes
  output logic [CNT_W-1:0] NEAR_END_BLOCK_ERROR_COUNT, // last second
  output logic [CNT_W-1:0] FAR_END_BLOCK_ERROR_COUNT, // last second
  output logic [CNT_W-1:0] OUTGOING_FAR_BLOCK_ERROR_COUNT, // last second
  output tcmdc_second_s DEFECT_SECONDS, // last second flags
  output logic IRQ // level interrupt
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("tcmdc_monitor: CNT_W out of range");
  end

  typedef enum logic {TCMDC_ALIGN_LOST, TCMDC_ALIGN_IN} tcmdc_align_e;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic inc);
    sat_inc = (inc && (v != '1)) ? v + CNT_W'(1) : v;
  endfunction

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  //////////////////////////////////////////////////////////////////////////////
  // registers and bus

  logic [TCMDC_CTRL_W-1:0] ctrl_q;
  logic [TCMDC_CTRL_W-1:0] ctrl_d;
  tcmdc_cause_s irq_sts_q;
  tcmdc_cause_s irq_sts_d;
  tcmdc_cause_s irq_mask_q;
  tcmdc_cause_s irq_mask_d;
  tcmdc_defect_s defects;
  tcmdc_cause_s cause_d;
  tcmdc_cause_s cause_q;

  wire wr_access = PSEL && PENABLE && PWRITE;
  wire hit_ctrl = PADDR == TCMDC_CTRL_OFS;
  wire hit_defect = PADDR == TCMDC_DEFECT_OFS;
  wire hit_cause = PADDR == TCMDC_CAUSE_OFS;
  wire hit_sts = PADDR == TCMDC_IRQ_STS_OFS;
  wire hit_mask = PADDR == TCMDC_IRQ_MASK_OFS;
  wire hit_near = PADDR == TCMDC_NEAR_CNT_OFS;
  wire hit_far = PADDR == TCMDC_FAR_CNT_OFS;
  wire hit_out = PADDR == TCMDC_OUT_CNT_OFS;
  wire hit_sec = PADDR == TCMDC_SECONDS_OFS;
  wire mapped = hit_ctrl | hit_defect | hit_cause | hit_sts | hit_mask
    | hit_near | hit_far | hit_out | hit_sec;

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = !(PSEL && !PWRITE) ? 32'h0000_0000
    : hit_ctrl ? 32'(ctrl_q)
    : hit_defect ? 32'(defects)
    : hit_cause ? 32'(cause_q)
    : hit_sts ? 32'(irq_sts_q)
    : hit_mask ? 32'(irq_mask_q)
    : hit_near ? 32'(NEAR_END_BLOCK_ERROR_COUNT)
    : hit_far ? 32'(FAR_END_BLOCK_ERROR_COUNT)
    : hit_out ? 32'(OUTGOING_FAR_BLOCK_ERROR_COUNT)
    : hit_sec ? 32'(DEFECT_SECONDS)
    : 32'h0000_0000;

  assign ctrl_d = (wr_access && hit_ctrl) ? PWDATA[TCMDC_CTRL_W-1:0] : ctrl_q;
  assign irq_mask_d = (wr_access && hit_mask) ? tcmdc_cause_s'(PWDATA[7:0]) : irq_mask_q;

  wire monitoring_enabled = tcmdc_mode_e'(ctrl_q[TCMDC_CTRL_MODE_BIT]) == TCMDC_MODE_MON;
  wire server_fail_report_enable = ctrl_q[TCMDC_CTRL_SSF_REP_BIT];
  wire remote_defect_report_enable = ctrl_q[TCMDC_CTRL_RDI_REP_BIT];
  wire outgoing_defect_report_enable = ctrl_q[TCMDC_CTRL_ODI_REP_BIT];
  wire incoming_alarm_report_enable = ctrl_q[TCMDC_CTRL_AIS_REP_BIT];
  wire mismatch_detect_disable = ctrl_q[TCMDC_CTRL_TIM_DIS_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // defect detection

  logic unequipped_defect;
  logic incoming_alarm_defect;
  tcmdc_align_e align_q;
  tcmdc_align_e align_d;
  logic bad_word_q;
  logic bad_word_d;

  tcmdc_persist #(
    .FRAMES(TCMDC_PERSIST_FRAMES)
  ) u_unequipped (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .frame(FRAME_START),
    .match(TC_OVERHEAD == TCMDC_UNEQ_CODE),
    .state_q(unequipped_defect)
  );

  tcmdc_persist #(
    .FRAMES(TCMDC_PERSIST_FRAMES)
  ) u_incoming_alarm (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .frame(FRAME_START),
    .match(TC_OVERHEAD[TCMDC_IEC_MSB:TCMDC_IEC_LSB] == TCMDC_IEC_AIS_CODE),
    .state_q(incoming_alarm_defect)
  );

  // multiframe alignment: two consecutive bad words lose it, one good regains
  always_comb begin
    align_d = align_q;
    bad_word_d = bad_word_q;
    if (MFA_WORD_STROBE) begin
      bad_word_d = MFA_WORD_ERROR;
      case (align_q)
        TCMDC_ALIGN_IN: begin
          if (MFA_WORD_ERROR && bad_word_q) begin
            align_d = TCMDC_ALIGN_LOST;
          end
        end
        TCMDC_ALIGN_LOST: begin
          if (!MFA_WORD_ERROR) begin
            align_d = TCMDC_ALIGN_IN;
          end
        end
        default: align_d = TCMDC_ALIGN_LOST;
      endcase
    end
  end

  wire multiframe_lost_state = align_q == TCMDC_ALIGN_LOST;
  wire multiframe_aligned_state = align_q == TCMDC_ALIGN_IN;

  always_comb begin
    defects.server_fail = SERVER_SIGNAL_FAIL_IN;
    defects.unequipped = unequipped_defect;
    defects.tandem_loss = multiframe_lost_state;
    defects.trace_mismatch = TRACE_MISMATCH_RAW && !SERVER_SIGNAL_FAIL_IN && !mismatch_detect_disable;
    defects.degrade = DEGRADE_DEFECT;
    defects.remote = REMOTE_DEFECT;
    defects.outgoing = OUTGOING_DEFECT;
    defects.incoming_alarm = incoming_alarm_defect;
    defects.equipment = EQUIPMENT_DEFECT;
  end

  //////////////////////////////////////////////////////////////////////////////
  // consequent actions and correlation

  wire tsf_d = defects.server_fail | defects.unequipped | defects.trace_mismatch | defects.tandem_loss;
  wire tsd_d = defects.degrade;
  wire uneq_tim_ltc = defects.unequipped | defects.trace_mismatch | defects.tandem_loss;

  always_comb begin
    cause_d.unequipped = monitoring_enabled && defects.unequipped;
    cause_d.tandem_loss = monitoring_enabled && !defects.unequipped && !defects.server_fail
      && defects.tandem_loss;
    cause_d.trace_mismatch = monitoring_enabled && !defects.unequipped && !defects.tandem_loss
      && defects.trace_mismatch;
    cause_d.degrade = monitoring_enabled && !defects.trace_mismatch && !defects.tandem_loss
      && defects.degrade;
    cause_d.server_fail = monitoring_enabled && defects.server_fail && server_fail_report_enable;
    cause_d.remote_defect = monitoring_enabled && !uneq_tim_ltc && defects.remote
      && remote_defect_report_enable;
    cause_d.outgoing_defect = monitoring_enabled && !uneq_tim_ltc && defects.outgoing
      && outgoing_defect_report_enable;
    cause_d.incoming_alarm = monitoring_enabled && defects.incoming_alarm && !defects.server_fail
      && !defects.tandem_loss && !defects.trace_mismatch && incoming_alarm_report_enable;
  end

  // rising fault causes raise sticky status; set wins over clear
  wire tcmdc_cause_s cause_rise = cause_d & ~cause_q;
  wire tcmdc_cause_s sts_clr = (wr_access && hit_sts) ? tcmdc_cause_s'(PWDATA[7:0]) : '0;
  assign irq_sts_d = (irq_sts_q & ~sts_clr) | cause_rise;
  assign IRQ = |(irq_sts_q & irq_mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // per-second performance monitoring

  logic [CNT_W-1:0] near_acc_q;
  logic [CNT_W-1:0] far_acc_q;
  logic [CNT_W-1:0] out_acc_q;
  tcmdc_second_s sec_acc_q;
  wire [CNT_W-1:0] near_sum = sat_inc(near_acc_q, FRAME_START && NEAR_ERRORED_BLOCK_FLAG);
  wire [CNT_W-1:0] far_sum = sat_inc(far_acc_q, FRAME_START && FAR_ERRORED_BLOCK_FLAG);
  wire [CNT_W-1:0] out_sum = sat_inc(out_acc_q, FRAME_START && OUTGOING_FAR_ERRORED_BLOCK_FLAG);
  tcmdc_second_s sec_now;
  always_comb begin
    sec_now.near_end = sec_acc_q.near_end | tsf_d | defects.equipment;
    sec_now.far_end = sec_acc_q.far_end | defects.remote;
    sec_now.outgoing_far = sec_acc_q.outgoing_far | defects.outgoing;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= TCMDC_CTRL_RST;
      irq_mask_q <= tcmdc_cause_s'(TCMDC_MASK_RST);
      irq_sts_q <= '0;
      cause_q <= '0;
      align_q <= TCMDC_ALIGN_LOST;
      bad_word_q <= 1'b0;
      TRAIL_SIGNAL_FAIL_OUT <= 1'b0;
      TRAIL_SIGNAL_DEGRADE_OUT <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_mask_q <= irq_mask_d;
      irq_sts_q <= irq_sts_d;
      cause_q <= cause_d;
      align_q <= align_d;
      bad_word_q <= bad_word_d;
      TRAIL_SIGNAL_FAIL_OUT <= tsf_d;
      TRAIL_SIGNAL_DEGRADE_OUT <= tsd_d;
    end
  end

  assign FAULT_CAUSES = cause_q;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      near_acc_q <= '0;
      far_acc_q <= '0;
      out_acc_q <= '0;
      sec_acc_q <= '0;
    end else if (ONE_SECOND) begin
      near_acc_q <= '0;
      far_acc_q <= '0;
      out_acc_q <= '0;
      sec_acc_q <= '0;
    end else begin
      near_acc_q <= near_sum;
      far_acc_q <= far_sum;
      out_acc_q <= out_sum;
      sec_acc_q <= sec_now;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      NEAR_END_BLOCK_ERROR_COUNT <= '0;
      FAR_END_BLOCK_ERROR_COUNT <= '0;
      OUTGOING_FAR_BLOCK_ERROR_COUNT <= '0;
      DEFECT_SECONDS <= '0;
    end else if (ONE_SECOND) begin
      NEAR_END_BLOCK_ERROR_COUNT <= near_sum;
      FAR_END_BLOCK_ERROR_COUNT <= far_sum;
      OUTGOING_FAR_BLOCK_ERROR_COUNT <= out_sum;
      DEFECT_SECONDS <= sec_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  AST_TSF: assert property ($past(RST_B) |-> TRAIL_SIGNAL_FAIL_OUT == $past(SERVER_SIGNAL_FAIL_IN
    | unequipped_defect | multiframe_lost_state | defects.trace_mismatch))
    else $error("trail signal fail wrong");
  AST_TSD: assert property ($rose(DEGRADE_DEFECT) && RST_B |=> TRAIL_SIGNAL_DEGRADE_OUT)
    else $error("trail signal degrade late");
  AST_UNEQ_CAUSE: assert property (unequipped_defect && monitoring_enabled |=> FAULT_CAUSES.unequipped)
    else $error("unequipped cause missing");
  AST_LTC_CAUSE: assert property (FAULT_CAUSES.tandem_loss |-> $past(multiframe_lost_state)
    && !$past(SERVER_SIGNAL_FAIL_IN) && !$past(unequipped_defect))
    else $error("tandem loss cause not gated");
  AST_TIM_CAUSE: assert property (FAULT_CAUSES.trace_mismatch |-> $past(TRACE_MISMATCH_RAW)
    && !$past(multiframe_lost_state) && !$past(unequipped_defect))
    else $error("mismatch cause not gated");
  AST_DEG_CAUSE: assert property (FAULT_CAUSES.degrade |-> $past(DEGRADE_DEFECT)
    && !$past(multiframe_lost_state) && !$past(defects.trace_mismatch))
    else $error("degrade cause not gated");
  AST_SSF_CAUSE: assert property (monitoring_enabled && server_fail_report_enable
    && SERVER_SIGNAL_FAIL_IN |=> FAULT_CAUSES.server_fail)
    else $error("server fail cause missing");
  AST_RDI_CAUSE: assert property (FAULT_CAUSES.remote_defect |-> $past(REMOTE_DEFECT)
    && !$past(uneq_tim_ltc) && $past(remote_defect_report_enable))
    else $error("remote cause not gated");
  AST_ODI_CAUSE: assert property (FAULT_CAUSES.outgoing_defect |-> $past(OUTGOING_DEFECT)
    && !$past(uneq_tim_ltc) && $past(outgoing_defect_report_enable))
    else $error("outgoing cause not gated");
  AST_AIS_CAUSE: assert property (FAULT_CAUSES.incoming_alarm |-> $past(incoming_alarm_defect)
    && !$past(SERVER_SIGNAL_FAIL_IN) && $past(incoming_alarm_report_enable))
    else $error("alarm cause not gated");
  AST_NEAR_SECOND: assert property (ONE_SECOND && EQUIPMENT_DEFECT |=> DEFECT_SECONDS.near_end)
    else $error("near defect second missed");
  AST_COUNT_LATCH: assert property (ONE_SECOND |=> NEAR_END_BLOCK_ERROR_COUNT == $past(near_sum)
    && near_acc_q == '0)
    else $error("count latch or restart wrong");
  AST_ALIGN_LOSS: assert property (multiframe_aligned_state && MFA_WORD_STROBE && MFA_WORD_ERROR
    && bad_word_q |=> multiframe_lost_state)
    else $error("alignment not lost");
  AST_ALIGN_GAIN: assert property (multiframe_lost_state && MFA_WORD_STROBE && !MFA_WORD_ERROR
    |=> !defects.tandem_loss)
    else $error("alignment not regained");
  AST_TIM_SUPPRESS: assert property (SERVER_SIGNAL_FAIL_IN || mismatch_detect_disable
    |-> !defects.trace_mismatch ##1 !FAULT_CAUSES.trace_mismatch)
    else $error("mismatch not suppressed");
  AST_MODE_OFF: assert property (!monitoring_enabled |=> FAULT_CAUSES == '0)
    else $error("cause active outside monitoring");
  AST_STS_SET: assert property (|cause_rise |=> (irq_sts_q & $past(cause_rise)) == $past(cause_rise))
    else $error("status bit lost");

endmodule
`default_nettype wire

// ---- core/tcmdc_persist.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcmdc_persist #(
  parameter int FRAMES = 5
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, low
  input wire logic frame, // one pulse per frame
  input wire logic match, // frame carries the code
  output logic state_q // filtered state
);

  localparam int W = $clog2(FRAMES + 1);
  localparam logic [W-1:0] LAST = W'(FRAMES - 1);

  if (FRAMES < 1 || FRAMES > 255) begin : g_chk
    $error("tcmdc_persist: FRAMES out of range");
  end

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic state_d;
  wire differs = frame && (match != state_q);
  wire flip = differs && (cnt_q == LAST);

  // count consecutive frames that disagree with the state
  assign cnt_d = !frame ? cnt_q : (!differs || flip) ? '0 : cnt_q + W'(1);
  assign state_d = flip ? match : state_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      state_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

endmodule
`default_nettype wire

// ---- shared/tcmdc_pkg.sv ----
`default_nettype none
package tcmdc_pkg;

  // register byte offsets
  localparam logic [7:0] TCMDC_CTRL_OFS = 8'h00;
  localparam logic [7:0] TCMDC_DEFECT_OFS = 8'h04;
  localparam logic [7:0] TCMDC_CAUSE_OFS = 8'h08;
  localparam logic [7:0] TCMDC_IRQ_STS_OFS = 8'h0c;
  localparam logic [7:0] TCMDC_IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] TCMDC_NEAR_CNT_OFS = 8'h14;
  localparam logic [7:0] TCMDC_FAR_CNT_OFS = 8'h18;
  localparam logic [7:0] TCMDC_OUT_CNT_OFS = 8'h1c;
  localparam logic [7:0] TCMDC_SECONDS_OFS = 8'h20;

  // control field positions
  localparam int TCMDC_CTRL_MODE_BIT = 0;
  localparam int TCMDC_CTRL_SSF_REP_BIT = 1;
  localparam int TCMDC_CTRL_RDI_REP_BIT = 2;
  localparam int TCMDC_CTRL_ODI_REP_BIT = 3;
  localparam int TCMDC_CTRL_AIS_REP_BIT = 4;
  localparam int TCMDC_CTRL_TIM_DIS_BIT = 5;
  localparam int TCMDC_CTRL_W = 6;
  localparam logic [5:0] TCMDC_CTRL_RST = 6'h00;
  localparam logic [7:0] TCMDC_MASK_RST = 8'h00;

  // tandem overhead byte
  localparam logic [7:0] TCMDC_UNEQ_CODE = 8'h00;
  localparam int TCMDC_IEC_MSB = 7;
  localparam int TCMDC_IEC_LSB = 4;
  localparam logic [3:0] TCMDC_IEC_AIS_CODE = 4'he;
  localparam int TCMDC_PERSIST_FRAMES = 5;
  localparam logic [1:0] TCMDC_LOSS_ERR_WORDS = 2'h2;
  localparam int TCMDC_CNT_W = 16;

  typedef enum logic {TCMDC_MODE_NONE, TCMDC_MODE_MON} tcmdc_mode_e;

  typedef struct packed {
    logic equipment;
    logic incoming_alarm;
    logic outgoing;
    logic remote;
    logic degrade;
    logic trace_mismatch;
    logic tandem_loss;
    logic unequipped;
    logic server_fail;
  } tcmdc_defect_s;

  typedef struct packed {
    logic incoming_alarm;
    logic outgoing_defect;
    logic remote_defect;
    logic server_fail;
    logic degrade;
    logic trace_mismatch;
    logic tandem_loss;
    logic unequipped;
  } tcmdc_cause_s;

  typedef struct packed {
    logic outgoing_far;
    logic far_end;
    logic near_end;
  } tcmdc_second_s;

endpackage
`default_nettype wire

// ---- verification/tc_monitor_defect_correlation_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tc_monitor_defect_correlation_tb_top;
  import tcmdc_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, fs, mst, mer, fail, degr, irq, one_sec = 1'b0;
  logic ssf = 1'b0, tim = 1'b0, deg = 1'b0, rdi = 1'b0, odi = 1'b0, eqp = 1'b0;
  logic [7:0] ov;
  logic [2:0] fl;
  logic [15:0] ncnt, fcnt, ocnt;
  tcmdc_cause_s causes;
  tcmdc_second_s secs;
  int fail_count = 0, compares = 0;
  logic [7:0] ex;

  always #2.5 clk_sys = ~clk_sys;

  tcmdc_frame_src tcmdc_frame_src_inst (.clk(clk_sys), .frame_start(fs), .overhead(ov), .blk_flags(fl),
    .mfa_strobe(mst), .mfa_error(mer));

  tcmdc_monitor tcmdc_monitor_inst (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FRAME_START(fs), .TC_OVERHEAD(ov), .MFA_WORD_STROBE(mst), .MFA_WORD_ERROR(mer),
    .SERVER_SIGNAL_FAIL_IN(ssf), .TRACE_MISMATCH_RAW(tim), .DEGRADE_DEFECT(deg), .REMOTE_DEFECT(rdi),
    .OUTGOING_DEFECT(odi), .EQUIPMENT_DEFECT(eqp), .NEAR_ERRORED_BLOCK_FLAG(fl[0]),
    .FAR_ERRORED_BLOCK_FLAG(fl[1]), .OUTGOING_FAR_ERRORED_BLOCK_FLAG(fl[2]), .ONE_SECOND(one_sec),
    .TRAIL_SIGNAL_FAIL_OUT(fail), .TRAIL_SIGNAL_DEGRADE_OUT(degr), .FAULT_CAUSES(causes),
    .NEAR_END_BLOCK_ERROR_COUNT(ncnt), .FAR_END_BLOCK_ERROR_COUNT(fcnt),
    .OUTGOING_FAR_BLOCK_ERROR_COUNT(ocnt), .DEFECT_SECONDS(secs), .IRQ(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic tick();
    @(posedge clk_sys);
    one_sec <= 1'b1;
    @(posedge clk_sys);
    one_sec <= 1'b0;
    settle();
  endtask

  task automatic test_done();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    settle();
    chk(fail, 1'b1);
    chk(causes, 8'h00);
    apb(1'b0, TCMDC_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, TCMDC_CTRL_OFS, 32'h1f);
    apb(1'b0, TCMDC_CTRL_OFS, 32'h0);
    chk(rd, 32'h1f);
    settle();
    chk(causes, 8'h02);
    ssf <= 1'b1;
    settle();
    chk(causes, 8'h10);
    ssf <= 1'b0;
    tcmdc_frame_src_inst.mfa(1'b0);
    settle();
    chk(fail, 1'b0);
    $display("test reset_and_bus done");
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys);
      {ssf, tim, deg, rdi, odi} <= i[4:0];
      settle();
      ex = {1'b0, i[0] & ~(i[3] & ~i[4]), i[1] & ~(i[3] & ~i[4]), i[4], i[2] & ~(i[3] & ~i[4]),
        i[3] & ~i[4], 2'b00};
      chk(fail, i[4] | i[3]);
      chk(degr, i[2]);
      chk(causes, ex);
    end
    {ssf, tim, deg, rdi, odi} <= 5'h0f;
    apb(1'b1, TCMDC_CTRL_OFS, 32'h3f);
    settle();
    chk(causes, 8'h68);
    chk(fail, 1'b0);
    {ssf, tim, deg, rdi, odi} <= 5'h00;
    apb(1'b1, TCMDC_CTRL_OFS, 32'h1f);
    $display("test correlation done");
    tcmdc_frame_src_inst.mfa(1'b1);
    settle();
    chk(fail, 1'b0);
    tcmdc_frame_src_inst.mfa(1'b1);
    settle();
    chk(fail, 1'b1);
    tcmdc_frame_src_inst.mfa(1'b0);
    for (int i = 0; i < 5; i++) begin
      settle();
      chk(causes.unequipped, 1'b0);
      tcmdc_frame_src_inst.send_frame(TCMDC_UNEQ_CODE, 3'h0);
    end
    settle();
    chk(causes, 8'h01);
    chk(fail, 1'b1);
    for (int i = 0; i < 5; i++) begin
      tcmdc_frame_src_inst.send_frame(8'he0, 3'h0);
    end
    settle();
    chk(causes, 8'h80);
    @(posedge clk_sys);
    ssf <= 1'b1;
    settle();
    chk(causes.incoming_alarm, 1'b0);
    ssf <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      tcmdc_frame_src_inst.send_frame(8'h11, 3'h0);
    end
    settle();
    chk(causes, 8'h00);
    $display("test filters done");
    apb(1'b1, TCMDC_IRQ_MASK_OFS, 32'hff);
    settle();
    chk(irq, 1'b1);
    apb(1'b1, TCMDC_IRQ_MASK_OFS, 32'h0);
    settle();
    chk(irq, 1'b0);
    apb(1'b1, TCMDC_IRQ_STS_OFS, 32'hff);
    apb(1'b0, TCMDC_IRQ_STS_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, TCMDC_IRQ_MASK_OFS, 32'hff);
    settle();
    chk(irq, 1'b0);
    $display("test interrupt done");
    tick();
    @(posedge clk_sys);
    rdi <= 1'b1;
    eqp <= 1'b1;
    tcmdc_frame_src_inst.send_frame(8'h11, 3'h7);
    tcmdc_frame_src_inst.send_frame(8'h11, 3'h3);
    tcmdc_frame_src_inst.send_frame(8'h11, 3'h1);
    rdi <= 1'b0;
    eqp <= 1'b0;
    tick();
    chk(ncnt, 16'h3);
    chk(fcnt, 16'h2);
    chk(ocnt, 16'h1);
    chk(secs, 3'h3);
    tick();
    chk({ncnt, fcnt}, 32'h0);
    chk({ocnt, 13'h0, secs}, 32'h0);
    $display("test per_second done");
    test_done();
  end
endmodule
`default_nettype wire

// ---- verification/tcmdc_frame_src.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcmdc_frame_src (
  input wire logic clk, // system clock
  output logic frame_start, // frame start pulse
  output logic [7:0] overhead, // tandem byte
  output logic [2:0] blk_flags, // outgoing, far, near errored
  output logic mfa_strobe, // alignment word checked
  output logic mfa_error // word had errors
);
  initial begin
    frame_start = 1'b0;
    overhead = 8'h5a;
    blk_flags = 3'h0;
    mfa_strobe = 1'b0;
    mfa_error = 1'b0;
  end

  // one frame; stale lines flip so nothing is read outside the pulse
  task automatic send_frame(input logic [7:0] ov, input logic [2:0] fl);
    @(posedge clk);
    frame_start <= 1'b1;
    overhead <= ov;
    blk_flags <= fl;
    @(posedge clk);
    frame_start <= 1'b0;
    overhead <= ~ov;
    blk_flags <= ~fl;
    repeat (2) @(posedge clk);
  endtask

  task automatic mfa(input logic err);
    @(posedge clk);
    mfa_strobe <= 1'b1;
    mfa_error <= err;
    @(posedge clk);
    mfa_strobe <= 1'b0;
    mfa_error <= ~err;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire
